// file: verilog/spe_eeprom_link.v
`timescale 1ns/10ps
`default_nettype none
`include "spe_defines.vh"

module spe_eeprom_link #(
   parameter WRITE_CYCLES = `SPE_T_WRITE_NS / `SPE_CLK_PERIOD_NS
) (
   // Clock and reset
   input  wire clk_sys,
   input  wire sys_rst,
   // Serial link pins
   input  wire cs_n,
   input  wire sck,
   input  wire si,
   input  wire hold_n,
   input  wire wp_n,
   output reg  so_out,
   output wire so_oe,
   // Status
   output wire write_busy
);

   // ----------------------------------------------------------------
   // Engine states
   // ----------------------------------------------------------------
   localparam ST_CMD    = 3'd0;
   localparam ST_ADDR_H = 3'd1;
   localparam ST_ADDR_L = 3'd2;
   localparam ST_READ   = 3'd3;
   localparam ST_WRITE  = 3'd4;
   localparam ST_SRDATA = 3'd5;
   localparam ST_RDSR   = 3'd6;
   localparam ST_IGNORE = 3'd7;

   function prot_hit;
      input [1:0]              bp;
      input [`SPE_ADDR_W-1:0]  a;
      begin
         case (bp)
            `SPE_BP_QUARTER: prot_hit = (a[`SPE_ADDR_W-1:`SPE_ADDR_W-2] == 2'h3);
            `SPE_BP_HALF:    prot_hit = a[`SPE_ADDR_W-1];
            `SPE_BP_ALL:     prot_hit = 1'b1;
            default:         prot_hit = 1'b0;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   reg [4:0] meta_reg;
   reg [4:0] sync_reg;
   reg       sck_prev_reg;
   reg       cs_prev_reg;
   wire      cs_s   = sync_reg[0];
   wire      sck_s  = sync_reg[1];
   wire      si_s   = sync_reg[2];
   wire      hold_s = sync_reg[3];
   wire      wp_s   = sync_reg[4];

   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         meta_reg     <= 5'h1F;
         sync_reg     <= 5'h1F;
         sck_prev_reg <= 1'b0;
         cs_prev_reg  <= 1'b1;
      end else begin
         meta_reg     <= {wp_n, hold_n, si, sck, cs_n};
         sync_reg     <= meta_reg;
         sck_prev_reg <= sck_s;
         cs_prev_reg  <= cs_s;
      end
   end

   // ----------------------------------------------------------------
   // Serial shifter
   // ----------------------------------------------------------------
   reg        held_reg;
   reg  [2:0] bit_cnt_reg;
   reg  [6:0] rx_shift_reg;
   reg  [7:0] tx_shift_reg;
   reg  [7:0] tx_byte_reg;
   reg        tx_active_reg;
   wire       selected  = ~cs_s;
   wire       live      = selected & ~held_reg;
   wire       sck_rise  = live & sck_s & ~sck_prev_reg;
   wire       sck_fall  = live & ~sck_s & sck_prev_reg;
   wire       cs_rise   = cs_s & ~cs_prev_reg;
   wire       byte_done = sck_rise & (bit_cnt_reg == 3'h7);
   wire       buf_out_valid;
   wire [7:0] buf_out_data;
   wire       eng_ready;

   assign so_oe = live & tx_active_reg;

   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         held_reg     <= 1'b0;
         bit_cnt_reg  <= 3'h0;
         rx_shift_reg <= 7'h00;
         tx_shift_reg <= 8'h00;
         so_out       <= 1'b0;
      end else begin
         // Suspend only follows the pin while the serial clock is low
         if (~selected)
            held_reg <= 1'b0;
         else if (~sck_s)
            held_reg <= ~hold_s;
         if (~selected) begin
            bit_cnt_reg <= 3'h0;
         end else if (sck_rise) begin
            rx_shift_reg <= {rx_shift_reg[5:0], si_s};
            bit_cnt_reg  <= bit_cnt_reg + 3'h1;
         end
         if (sck_fall & tx_active_reg) begin
            if (bit_cnt_reg == 3'h0) begin
               so_out       <= tx_byte_reg[7];
               tx_shift_reg <= {tx_byte_reg[6:0], 1'b0};
            end else begin
               so_out       <= tx_shift_reg[7];
               tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
            end
         end
      end
   end

   // A full buffer cannot happen at legal clock rates; a byte arriving then is dropped
   spe_buf2 #(.WIDTH(8)) u_rx_buf (
      .clk_sys   (clk_sys),
      .sys_rst   (sys_rst),
      .in_valid  (byte_done),
      .in_ready  (),
      .in_data   ({rx_shift_reg, si_s}),
      .out_valid (buf_out_valid),
      .out_ready (eng_ready),
      .out_data  (buf_out_data)
   );

   // ----------------------------------------------------------------
   // Command engine and array
   // ----------------------------------------------------------------
   reg [7:0]              mem_arr [0:`SPE_MEM_WORDS-1];
   reg [2:0]              state_reg;
   reg                    is_write_reg;
   reg [`SPE_ADDR_W-1:0]  addr_reg;
   reg                    wr_gap_reg;
   reg                    end_pend_reg;
   reg                    wel_reg;
   reg                    busy_reg;
   reg [1:0]              bp_reg;
   reg                    ppe_reg;
   reg [7:0]              sr_data_reg;
   reg                    sr_pend_reg;
   reg                    sr_abort_reg;
   reg                    sr_commit_reg;
   reg                    wrote_reg;
   reg [18:0]             timer_reg;
   wire                   pop        = buf_out_valid & eng_ready;
   wire                   wp_block   = ~wp_s & ppe_reg;
   wire [7:0]             status_val = {ppe_reg, 3'h0, bp_reg, wel_reg, busy_reg};
   wire [`SPE_ADDR_W-1:0] addr_inc   = addr_reg + 1'b1;

   // Stall one cycle after each array write so the buffer sees back-pressure
   assign eng_ready  = ~wr_gap_reg;
   assign write_busy = busy_reg;

   always @(posedge clk_sys) begin
      if (pop & (state_reg == ST_WRITE) & ~prot_hit(bp_reg, addr_reg))
         mem_arr[addr_reg] <= buf_out_data;
   end

   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg     <= ST_CMD;
         is_write_reg  <= 1'b0;
         addr_reg      <= {`SPE_ADDR_W{1'b0}};
         wr_gap_reg    <= 1'b0;
         end_pend_reg  <= 1'b0;
         tx_active_reg <= 1'b0;
         tx_byte_reg   <= 8'h00;
         wel_reg       <= 1'b0;
         busy_reg      <= 1'b0;
         bp_reg        <= `SPE_BP_RESET;
         ppe_reg       <= `SPE_PPE_RESET;
         sr_data_reg   <= 8'h00;
         sr_pend_reg   <= 1'b0;
         sr_abort_reg  <= 1'b0;
         sr_commit_reg <= 1'b0;
         wrote_reg     <= 1'b0;
         timer_reg     <= 19'h0_0000;
      end else begin
         wr_gap_reg <= 1'b0;
         if (cs_rise)
            end_pend_reg <= 1'b1;
         // Pin low with ppe_reg set while still selected kills a pending status write
         if (selected & (state_reg == ST_SRDATA || sr_pend_reg) & wp_block)
            sr_abort_reg <= 1'b1;
         if (pop) begin
            case (state_reg)
               ST_CMD: begin
                  case (buf_out_data)
                     `SPE_OP_WR_ENABLE:  if (~busy_reg) wel_reg <= 1'b1;
                     `SPE_OP_WR_DISABLE: if (~busy_reg) wel_reg <= 1'b0;
                     default: ;
                  endcase
                  if (buf_out_data == `SPE_OP_RD_STATUS) begin
                     tx_byte_reg   <= status_val;
                     tx_active_reg <= 1'b1;
                     state_reg     <= ST_RDSR;
                  end else if (busy_reg) begin
                     state_reg <= ST_IGNORE;
                  end else if (buf_out_data == `SPE_OP_WR_STATUS) begin
                     state_reg <= ST_SRDATA;
                  end else if (buf_out_data == `SPE_OP_READ ||
                               (buf_out_data == `SPE_OP_WRITE && wel_reg)) begin
                     is_write_reg <= (buf_out_data == `SPE_OP_WRITE);
                     state_reg    <= ST_ADDR_H;
                  end else begin
                     state_reg <= ST_IGNORE;
                  end
               end
               ST_ADDR_H: begin
                  addr_reg[`SPE_ADDR_W-1:8] <= buf_out_data[`SPE_ADDR_W-9:0];
                  state_reg                 <= ST_ADDR_L;
               end
               ST_ADDR_L: begin
                  if (is_write_reg) begin
                     addr_reg[7:0] <= buf_out_data;
                     state_reg     <= ST_WRITE;
                  end else begin
                     tx_byte_reg   <= mem_arr[{addr_reg[`SPE_ADDR_W-1:8], buf_out_data}];
                     addr_reg      <= {addr_reg[`SPE_ADDR_W-1:8], buf_out_data} + 1'b1;
                     tx_active_reg <= 1'b1;
                     state_reg     <= ST_READ;
                  end
               end
               ST_READ: begin
                  tx_byte_reg <= mem_arr[addr_reg];
                  addr_reg    <= addr_inc;
               end
               ST_WRITE: begin
                  // Address wraps inside the page
                  addr_reg[`SPE_PAGE_W-1:0] <= addr_inc[`SPE_PAGE_W-1:0];
                  wr_gap_reg                <= 1'b1;
                  if (~prot_hit(bp_reg, addr_reg))
                     wrote_reg <= 1'b1;
               end
               ST_SRDATA: begin
                  sr_data_reg <= buf_out_data;
                  sr_pend_reg <= 1'b1;
                  state_reg   <= ST_IGNORE;
               end
               ST_RDSR:
                  tx_byte_reg <= status_val;
               ST_IGNORE: ;
               default:
                  state_reg <= ST_IGNORE;
            endcase
         end else if (end_pend_reg & ~buf_out_valid) begin
            // Frame over: decoder back to opcode, start any nonvolatile cycle
            end_pend_reg  <= 1'b0;
            state_reg     <= ST_CMD;
            tx_active_reg <= 1'b0;
            sr_pend_reg   <= 1'b0;
            sr_abort_reg  <= 1'b0;
            wrote_reg     <= 1'b0;
            if (sr_pend_reg & wel_reg & ~sr_abort_reg & ~wp_block) begin
               sr_commit_reg <= 1'b1;
               busy_reg      <= 1'b1;
               timer_reg     <= 19'h0_0000;
            end else if (wrote_reg) begin
               busy_reg  <= 1'b1;
               timer_reg <= 19'h0_0000;
            end
         end
         // Once started, the cycle runs out regardless of the protect pin
         if (busy_reg) begin
            if (timer_reg == WRITE_CYCLES[18:0] - 19'h0_0001) begin
               busy_reg      <= 1'b0;
               wel_reg       <= 1'b0;
               sr_commit_reg <= 1'b0;
               if (sr_commit_reg) begin
                  ppe_reg <= sr_data_reg[`SPE_ST_PPE_BIT];
                  bp_reg  <= sr_data_reg[`SPE_ST_BP_MSB:`SPE_ST_BP_LSB];
               end
            end else begin
               timer_reg <= timer_reg + 19'h0_0001;
            end
         end
      end
   end

endmodule // spe_eeprom_link

`default_nettype wire

// file: verilog/spe_defines.vh
`ifndef SPE_DEFINES_VH
`define SPE_DEFINES_VH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SPE_CLK_PERIOD_NS 10
`define SPE_T_WRITE_NS    5000000

// ----------------------------------------------------------------
// Array and page
// ----------------------------------------------------------------
`define SPE_ADDR_W        15
`define SPE_MEM_WORDS     32768
`define SPE_PAGE_W        6

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define SPE_OP_WR_STATUS  8'h01
`define SPE_OP_WRITE      8'h02
`define SPE_OP_READ       8'h03
`define SPE_OP_WR_DISABLE 8'h04
`define SPE_OP_RD_STATUS  8'h05
`define SPE_OP_WR_ENABLE  8'h06

// ----------------------------------------------------------------
// Status byte fields and reset values
// ----------------------------------------------------------------
`define SPE_ST_BUSY_BIT   0
`define SPE_ST_WEL_BIT    1
`define SPE_ST_BP_LSB     2
`define SPE_ST_BP_MSB     3
`define SPE_ST_PPE_BIT    7
`define SPE_BP_RESET      2'h0
`define SPE_PPE_RESET     1'h0

// ----------------------------------------------------------------
// Block protect encodings
// ----------------------------------------------------------------
`define SPE_BP_NONE       2'h0
`define SPE_BP_QUARTER    2'h1
`define SPE_BP_HALF       2'h2
`define SPE_BP_ALL        2'h3

`endif

// file: verilog/spe_buf2.v
`timescale 1ns/10ps
`default_nettype none

module spe_buf2 #(
   parameter WIDTH = 8
) (
   // Clock and reset
   input  wire             clk_sys,
   input  wire             sys_rst,
   // Fill side
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   // Drain side
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);

   reg [WIDTH-1:0] slot_reg [0:1];
   reg             wr_ptr_reg;
   reg             rd_ptr_reg;
   reg [1:0]       count_reg;
   wire            push;
   wire            pop;

   assign in_ready  = (count_reg != 2'h2);
   assign out_valid = (count_reg != 2'h0);
   assign out_data  = slot_reg[rd_ptr_reg];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         count_reg  <= 2'h0;
      end else begin
         if (push)
            wr_ptr_reg <= ~wr_ptr_reg;
         if (pop)
            rd_ptr_reg <= ~rd_ptr_reg;
         if (push & ~pop)
            count_reg <= count_reg + 2'h1;
         else if (pop & ~push)
            count_reg <= count_reg - 2'h1;
      end
   end

   // Storage needs no reset; valid is held by the count
   always @(posedge clk_sys) begin
      if (push)
         slot_reg[wr_ptr_reg] <= in_data;
   end

endmodule // spe_buf2

`default_nettype wire

// file: testbench/spe_link_chk_properties.sv
`timescale 1ns/10ps
`default_nettype none
module spe_link_chk #(
   parameter int WRITE_CYCLES = 50
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Link pins
   input wire logic cs_n,
   input wire logic sck,
   input wire logic si,
   input wire logic hold_n,
   input wire logic wp_n,
   input wire logic so_out,
   input wire logic so_oe,
   // Status
   input wire logic write_busy
);
   // ----
   // Busy length
   // ----
   logic [31:0] bcnt_reg;
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst)
         bcnt_reg <= 32'h0000_0000;
      else
         bcnt_reg <= write_busy ? bcnt_reg + 32'h0000_0001 : 32'h0000_0000;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // Synchroniser delay allows a few cycles of slack after each pin change
   property p_desel_off; cs_n [*5] |-> !so_oe; endproperty
   a_desel_off: assert property (p_desel_off) else $error("output on while deselected");
   property p_oe_sel; so_oe |-> !$past(cs_n, 6); endproperty
   a_oe_sel: assert property (p_oe_sel) else $error("output on after frame end");
   property p_hold_off; (!hold_n && !sck) [*5] |-> !so_oe; endproperty
   a_hold_off: assert property (p_hold_off) else $error("output on while suspended");
   property p_so_fall;
      $changed(so_out) && so_oe && $past(so_oe) |-> !$past(sck, 3) || !$past(sck, 4) || !$past(sck, 5);
   endproperty
   a_so_fall: assert property (p_so_fall) else $error("data changed away from falling clock");
   property p_oe_rise;
      $rose(so_oe) |-> !$past(cs_n, 4) && (!$past(sck, 3) || !$past(sck, 4) || !$past(sck, 5));
   endproperty
   a_oe_rise: assert property (p_oe_rise) else $error("output enabled off a falling clock");
   property p_busy_len; $fell(write_busy) |-> bcnt_reg >= WRITE_CYCLES && bcnt_reg <= WRITE_CYCLES + 2; endproperty
   a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong");
   property p_busy_cs; $rose(write_busy) |-> cs_n && $past(cs_n); endproperty
   a_busy_cs: assert property (p_busy_cs) else $error("write cycle began while selected");
   property p_busy_wp; write_busy && !wp_n && bcnt_reg < WRITE_CYCLES - 1 |=> write_busy; endproperty
   a_busy_wp: assert property (p_busy_wp) else $error("protect pin cut a write cycle short");
   c_busy: cover property ($fell(write_busy));
   c_read: cover property ($rose(so_oe));
   c_hold: cover property (!hold_n && !cs_n);
endmodule // spe_link_chk
bind spe_eeprom_link spe_link_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
   .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe),
   .write_busy(write_busy));
`default_nettype wire

// file: testbench/spe_master.sv
`timescale 1ns/10ps
`default_nettype none
module spe_master (
   // Bench clock, used only to keep pin changes off its edges
   input  wire logic clk_sys,
   // Link pins
   output var logic cs_n,
   output var logic sck,
   output var logic si,
   output var logic hold_n,
   input  wire logic so_out,
   input  wire logic so_oe
);
   localparam real HP = 62.5;
   logic cpol;
   // Undriven data out reads as high impedance (z), never as a stale bit
   wire logic so_pin = so_oe ? so_out : 1'bz;
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
      hold_n = 1'b1;
      cpol = 1'b0;
   end
   // Half bit times are 62.5 ns, so start 1.25 ns past a falling edge:
   // every later pin change then lands 1.25 ns or 3.75 ns off any clock edge
   task automatic sel();
      @(negedge clk_sys);
      #1.25;
      sck = cpol;
      #HP;
      cs_n = 1'b0;
      #HP;
   endtask
   task automatic desel();
      if (!cpol) sck = 1'b0;
      #HP;
      cs_n = 1'b1;
      si = ~si;
      #100;
   endtask
   task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         sck = 1'b0;
         si = tx[i];
         #HP;
         sck = 1'b1;
         rx[i] = so_pin;
         #HP;
      end
   endtask
   task automatic frame(input logic [7:0] q[$], output logic [7:0] rx);
      sel();
      foreach (q[i]) xb(q[i], rx);
      desel();
   endtask
   // Suspend is entered and left only with the clock low
   task automatic pause(output logic oe);
      sck = 1'b0;
      #HP;
      hold_n = 1'b0;
      #HP;
      repeat (2) begin
         sck = 1'b1;
         si = ~si;
         #HP;
         sck = 1'b0;
         #HP;
      end
      oe = so_oe;
      hold_n = 1'b1;
      #HP;
   endtask
endmodule // spe_master
`default_nettype wire

// file: testbench/test_spe_eeprom_link.sv
`timescale 1ns/10ps
`default_nettype none
module test_spe_eeprom_link;
   localparam int WC = 50;
   logic      clk_sys;
   logic      sys_rst;
   logic      wp_n;
   wire logic cs_n;
   wire logic sck;
   wire logic si;
   wire logic hold_n;
   wire logic so_out;
   wire logic so_oe;
   wire logic write_busy;
   int        n_errors = 0;
   int        n_tests = 0;
   int        cyc = 0;
   spe_eeprom_link #(.WRITE_CYCLES(WC)) DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .cs_n(cs_n), .sck(sck),
      .si(si), .hold_n(hold_n), .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe), .write_busy(write_busy));
   spe_master m (.clk_sys(clk_sys), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .so_out(so_out),
      .so_oe(so_oe));
   // ----
   // Helpers
   // ----
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] q[$], input logic busy);
      logic [7:0] rx;
      m.frame('{8'h06}, rx);
      m.frame(q, rx);
      @(negedge clk_sys);
      chk("busy", {7'h00, busy}, {7'h00, write_busy});
      for (int i = 0; i < 200 && write_busy !== 1'b0; i++) @(negedge clk_sys);
      chk("busy end", 8'h00, {7'h00, write_busy});
   endtask
   task automatic rdsr(input logic [7:0] exp, input logic [7:0] mask);
      logic [7:0] rx;
      m.frame('{8'h05, 8'h00}, rx);
      chk("status", exp, rx & mask);
   endtask
   // ----
   // Scenarios
   // ----
   task automatic t_status();
      logic [7:0] rx;
      m.sel();
      m.desel();
      rdsr(8'h00, 8'hFF);
      m.xb(8'h06, rx);
      chk("idle data out", 8'hzz, rx);
      m.frame('{8'h02, 8'h00, 8'h10, 8'h55}, rx);
      @(negedge clk_sys);
      chk("busy unselected", 8'h00, {7'h00, write_busy});
      wr('{8'h01, 8'h8C}, 1'b1);
      rdsr(8'h8C, 8'hFF);
      wr('{8'h02, 8'h00, 8'h10, 8'h55}, 1'b0);
      $display("status test done");
   endtask
   task automatic t_prot();
      @(negedge clk_sys) wp_n = 1'b0;
      wr('{8'h01, 8'h00}, 1'b0);
      rdsr(8'h8C, 8'hFD);
      @(negedge clk_sys) wp_n = 1'b1;
      fork
         wr('{8'h01, 8'h00}, 1'b0);
         begin
            // Pin dips during the data byte and is high again at frame end
            #3000;
            @(negedge clk_sys) wp_n = 1'b0;
            #200;
            @(negedge clk_sys) wp_n = 1'b1;
         end
      join
      rdsr(8'h8C, 8'hFD);
      $display("protect test done");
   endtask
   task automatic t_late();
      @(negedge clk_sys) wp_n = 1'b1;
      fork
         wr('{8'h01, 8'h00}, 1'b1);
         begin
            wait (write_busy === 1'b1);
            @(negedge clk_sys) wp_n = 1'b0;
         end
      join
      rdsr(8'h00, 8'hFF);
      wr('{8'h01, 8'h04}, 1'b1);
      rdsr(8'h04, 8'hFF);
      wr('{8'h02, 8'h60, 8'h00, 8'h11}, 1'b0);
      wr('{8'h02, 8'h50, 8'h00, 8'h22}, 1'b1);
      wr('{8'h01, 8'h00}, 1'b1);
      $display("late protect test done");
   endtask
   task automatic t_array(input logic mode, input logic [7:0] hi, input logic [7:0] a, input logic [7:0] b);
      logic [7:0] rx;
      logic       oe;
      m.cpol = mode;
      wr('{8'h02, 8'h7F, 8'hFE, a, b}, 1'b1);
      m.sel();
      m.xb(8'h03, rx);
      m.xb(hi, rx);
      m.xb(8'hFE, rx);
      m.xb(8'h00, rx);
      chk("read byte 0", a, rx);
      m.pause(oe);
      chk("held output", 8'h00, {7'h00, oe});
      m.xb(8'h00, rx);
      chk("read byte 1", b, rx);
      m.desel();
      $display("array test mode %0d done", mode);
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ----
   // Clock, timeout and sequence
   // ----
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 30000) begin
         n_errors++;
         report_and_stop();
      end
   end
   initial begin
      sys_rst = 1'b1;
      wp_n = 1'b1;
      repeat (10) @(negedge clk_sys);
      sys_rst = 1'b0;
      repeat (3) @(negedge clk_sys);
      t_status();
      t_prot();
      t_late();
      t_array(1'b0, 8'h7F, 8'hA5, 8'h3C);
      t_array(1'b1, 8'hFF, 8'h5A, 8'hC3);
      report_and_stop();
   end
endmodule // test_spe_eeprom_link
`default_nettype wire
